// ---- hdl/rfc_pkg.sv ----
package rfc_pkg;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] TX_SETUP_IDX    = 8'h2c;
	localparam logic [7:0] RX_SETUP_IDX    = 8'h2d;
	localparam logic [7:0] STATUS_IDX      = 8'h40;
	localparam logic [7:0] MASK_IDX        = 8'h41;
	localparam logic [7:0] USER_PRESET_IDX = 8'h42;
	localparam logic [7:0] RESULT_IDX      = 8'h43;
	localparam int         AV_ADDR_W       = 10;

	// Values after reset
	localparam logic [7:0]  TX_SETUP_RESET    = 8'h00;
	localparam logic [7:0]  RX_SETUP_RESET    = 8'h00;
	localparam logic [15:0] USER_PRESET_RESET = 16'h0000;
	localparam logic [2:0]  STATUS_RESET      = 3'h0;
	localparam logic [2:0]  MASK_RESET        = 3'h0;
	// Bit 7 of the transmit setup is reserved and reads zero
	localparam logic [7:0]  TX_SETUP_WMASK    = 8'h7f;

	// Status and mask bit positions
	localparam int STATUS_W  = 3;
	localparam int ST_TX_END = 0;
	localparam int ST_RX_END = 1;
	localparam int ST_RX_ERR = 2;

	// Checksum width codes
	typedef enum logic [1:0] {
		RFC_W5  = 2'h0,
		RFC_W8  = 2'h1,
		RFC_W16 = 2'h2,
		RFC_WRS = 2'h3
	} rfc_width_t;

	// Initial value codes
	localparam logic [2:0] PRE_ZERO = 3'h0;
	localparam logic [2:0] PRE_A    = 3'h1;
	localparam logic [2:0] PRE_B    = 3'h2;
	localparam logic [2:0] PRE_C    = 3'h3;
	localparam logic [2:0] PRE_USER = 3'h6;
	localparam logic [2:0] PRE_ONES = 3'h7;

	// Initial values per width
	localparam logic [15:0] P16_A    = 16'h6363;
	localparam logic [7:0]  P8_A     = 8'h12;
	localparam logic [15:0] P16_B    = 16'ha671;
	localparam logic [7:0]  P8_B     = 8'hbf;
	localparam logic [15:0] P16_C    = 16'hfffe;
	localparam logic [7:0]  P8_C     = 8'hfd;
	localparam logic [15:0] P16_ONES = 16'hffff;
	localparam logic [7:0]  P8_ONES  = 8'hff;
	localparam logic [4:0]  P5_ONES  = 5'h1f;

	// Generator polynomials, bit-reversed for LSB-first shifting
	localparam logic [15:0] POLY16 = 16'h8408;
	localparam logic [15:0] POLY8  = 16'h00b8;
	localparam logic [15:0] POLY5  = 16'h0012;

	typedef struct packed {
		logic       reserved;
		logic [2:0] tx_initial_value_select;
		rfc_width_t tx_checksum_width_select;
		logic       tx_checksum_complement;
		logic       tx_checksum_append_enable;
	} rfc_tx_setup_t;

	typedef struct packed {
		logic       rx_checksum_store_to_fifo;
		logic [2:0] rx_initial_value_select;
		rfc_width_t rx_checksum_width_select;
		logic       rx_checksum_complement;
		logic       rx_checksum_verify_enable;
	} rfc_rx_setup_t;

	// One byte of a frame stream
	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} rfc_beat_t;

endpackage : rfc_pkg

// ---- hdl/rfc_frame_crc.sv ----
`timescale 1ns/1ps
module rfc_frame_crc (
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	input  wire logic [rfc_pkg::AV_ADDR_W-1:0] avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [3:0]                    avs_byteenable,
	input  wire logic [31:0]                   avs_writedata,
	output logic      [31:0]                   avs_readdata,
	output logic                               avs_waitrequest,
	output logic                               irq,
	input  wire logic                          tx_in_valid,
	input  wire rfc_pkg::rfc_beat_t            tx_in_beat,
	output logic                               tx_in_ready,
	output logic                               tx_out_valid,
	output rfc_pkg::rfc_beat_t                 tx_out_beat,
	input  wire logic                          tx_out_ready,
	input  wire logic                          rx_in_valid,
	input  wire rfc_pkg::rfc_beat_t            rx_in_beat,
	output logic                               fifo_wr_en,
	output logic      [7:0]                    fifo_wr_data,
	output logic                               rx_checksum_error
);

	typedef enum logic [2:0] {
		TX_DATA = 3'b001,
		TX_CRC0 = 3'b010,
		TX_CRC1 = 3'b100
	} rfc_tx_state_t;

	// Start value for a code and width; undefined codes give zero
	function automatic logic [15:0] preset_of(input logic [2:0] code,
		input rfc_pkg::rfc_width_t w, input logic [15:0] user);
		logic [15:0] v;
		v = 16'h0000;
		case (code)
			rfc_pkg::PRE_ZERO: v = 16'h0000;
			rfc_pkg::PRE_A:    v = (w == rfc_pkg::RFC_W16) ? rfc_pkg::P16_A
				: {8'h00, rfc_pkg::P8_A};
			rfc_pkg::PRE_B:    v = (w == rfc_pkg::RFC_W16) ? rfc_pkg::P16_B
				: (w == rfc_pkg::RFC_W8) ? {8'h00, rfc_pkg::P8_B} : 16'h0000;
			rfc_pkg::PRE_C:    v = (w == rfc_pkg::RFC_W16) ? rfc_pkg::P16_C
				: (w == rfc_pkg::RFC_W8) ? {8'h00, rfc_pkg::P8_C} : 16'h0000;
			rfc_pkg::PRE_USER: v = user;
			rfc_pkg::PRE_ONES: v = (w == rfc_pkg::RFC_W16) ? rfc_pkg::P16_ONES
				: (w == rfc_pkg::RFC_W8) ? {8'h00, rfc_pkg::P8_ONES}
				: {11'h000, rfc_pkg::P5_ONES};
			default:           v = 16'h0000;
		endcase
		return v & width_mask(w);
	endfunction : preset_of

	// Bits that carry checksum for a width
	function automatic logic [15:0] width_mask(input rfc_pkg::rfc_width_t w);
		case (w)
			rfc_pkg::RFC_W5:  return 16'h001f;
			rfc_pkg::RFC_W8:  return 16'h00ff;
			rfc_pkg::RFC_W16: return 16'hffff;
			default:          return 16'h0000;
		endcase
	endfunction : width_mask

	// Checksum bytes on the air; the reserved width carries none
	function automatic logic [1:0] byte_count(input rfc_pkg::rfc_width_t w);
		case (w)
			rfc_pkg::RFC_W16: return 2'd2;
			rfc_pkg::RFC_WRS: return 2'd0;
			default:          return 2'd1;
		endcase
	endfunction : byte_count

	// One byte through the shift register, LSB first
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d, input rfc_pkg::rfc_width_t w);
		logic [15:0] r;
		logic [15:0] p;
		r = c;
		p = (w == rfc_pkg::RFC_W16) ? rfc_pkg::POLY16
			: (w == rfc_pkg::RFC_W8) ? rfc_pkg::POLY8 : rfc_pkg::POLY5;
		for (int i = 0; i < 8; i++)
		begin
			if (r[0] ^ d[i])
				r = (r >> 1) ^ p;
			else
				r = r >> 1;
		end
		return r & width_mask(w);
	endfunction : crc_step

	rfc_pkg::rfc_tx_setup_t  tx_setup;
	rfc_pkg::rfc_rx_setup_t  rx_setup;
	logic [15:0]             user_preset;
	logic [rfc_pkg::STATUS_W-1:0] status;
	logic [rfc_pkg::STATUS_W-1:0] mask;
	logic [15:0]             rx_result;
	logic [7:0]              reg_idx;
	logic                    wr_go;
	logic                    tx_end_ev;
	logic                    rx_end_ev;
	logic                    rx_err_ev;

	assign reg_idx = avs_address[9:2];
	assign wr_go   = avs_write && !avs_waitrequest && avs_byteenable[0];

	// One wait state: the access completes on the second edge it is held
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	// Read data settles with waitrequest low; unmapped reads give zero
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && avs_waitrequest)
		begin
			case (reg_idx)
				rfc_pkg::TX_SETUP_IDX:    avs_readdata <= {24'h00_0000, tx_setup};
				rfc_pkg::RX_SETUP_IDX:    avs_readdata <= {24'h00_0000, rx_setup};
				rfc_pkg::STATUS_IDX:      avs_readdata <= {29'h0, status};
				rfc_pkg::MASK_IDX:        avs_readdata <= {29'h0, mask};
				rfc_pkg::USER_PRESET_IDX: avs_readdata <= {16'h0000, user_preset};
				rfc_pkg::RESULT_IDX:      avs_readdata <= {16'h0000, rx_result};
				default:                  avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers; the user value stands in for stored config
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_setup    <= rfc_pkg::rfc_tx_setup_t'(rfc_pkg::TX_SETUP_RESET);
			rx_setup    <= rfc_pkg::rfc_rx_setup_t'(rfc_pkg::RX_SETUP_RESET);
			user_preset <= rfc_pkg::USER_PRESET_RESET;
			mask        <= rfc_pkg::MASK_RESET;
		end
		else if (wr_go)
		begin
			case (reg_idx)
				rfc_pkg::TX_SETUP_IDX: tx_setup <= rfc_pkg::rfc_tx_setup_t'(
					avs_writedata[7:0] & rfc_pkg::TX_SETUP_WMASK);
				rfc_pkg::RX_SETUP_IDX: rx_setup <=
					rfc_pkg::rfc_rx_setup_t'(avs_writedata[7:0]);
				rfc_pkg::MASK_IDX:     mask <= avs_writedata[2:0];
				rfc_pkg::USER_PRESET_IDX:
				begin
					user_preset[7:0] <= avs_writedata[7:0];
					if (avs_byteenable[1])
						user_preset[15:8] <= avs_writedata[15:8];
				end
				default: ;
			endcase
		end
	end

	// Sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			status <= rfc_pkg::STATUS_RESET;
		else
		begin
			status <= (status & ~((wr_go && reg_idx == rfc_pkg::STATUS_IDX)
				? avs_writedata[2:0] : 3'h0))
				| {rx_err_ev, rx_end_ev, tx_end_ev};
		end
	end

	// Level interrupt from any unmasked status bit
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	rfc_tx_state_t tx_state;
	rfc_tx_state_t next_tx_state;
	logic [15:0]   tx_crc;
	logic [15:0]   tx_final;
	logic          tx_first;
	logic          tx_accept;
	logic          tx_load;
	rfc_pkg::rfc_beat_t tx_load_beat;
	logic          next_tx_out_valid;
	logic [1:0]    tx_nbytes;
	logic          tx_free;

	assign tx_nbytes = tx_setup.tx_checksum_append_enable
		? byte_count(tx_setup.tx_checksum_width_select) : 2'd0;
	assign tx_accept = tx_in_valid && tx_in_ready;
	assign tx_free   = !tx_out_valid || tx_out_ready;
	assign tx_end_ev = tx_out_valid && tx_out_ready && tx_out_beat.last;
	// Complement covers only the bits of the chosen width
	assign tx_final  = tx_setup.tx_checksum_complement
		? (tx_crc ^ width_mask(tx_setup.tx_checksum_width_select))
		: tx_crc;

	// Transmit sequencing: data, then the low checksum byte and, for 16-bit width only, the high one
	always_comb
	begin
		next_tx_state = tx_state;
		tx_load       = 1'b0;
		tx_load_beat  = tx_in_beat;
		case (tx_state)
			TX_DATA:
			begin
				tx_load      = tx_accept;
				tx_load_beat.last = tx_in_beat.last && (tx_nbytes == 2'd0);
				if (tx_accept && tx_in_beat.last && tx_nbytes != 2'd0)
					next_tx_state = TX_CRC0;
			end
			TX_CRC0:
			begin
				tx_load      = tx_free;
				tx_load_beat = '{last: (tx_nbytes == 2'd1),
					data: tx_final[7:0]};
				if (tx_free)
					next_tx_state = (tx_nbytes == 2'd2) ? TX_CRC1 : TX_DATA;
			end
			TX_CRC1:
			begin
				tx_load      = tx_free;
				tx_load_beat = '{last: 1'b1, data: tx_final[15:8]};
				if (tx_free)
					next_tx_state = TX_DATA;
			end
			default: next_tx_state = TX_DATA;
		endcase
		next_tx_out_valid = tx_load || (tx_out_valid && !tx_out_ready);
	end

	// State and the single output stage toward the bit coder
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_state     <= TX_DATA;
			tx_out_valid <= 1'b0;
			tx_out_beat  <= '0;
			tx_in_ready  <= 1'b0;
		end
		else
		begin
			tx_state     <= next_tx_state;
			tx_out_valid <= next_tx_out_valid;
			if (tx_load)
				tx_out_beat <= tx_load_beat;
			// Half rate: a byte is taken only into an empty stage
			tx_in_ready <= (next_tx_state == TX_DATA) && !next_tx_out_valid;
		end
	end

	// Running checksum, reloaded from the start value on a frame's first byte
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_crc   <= 16'h0000;
			tx_first <= 1'b1;
		end
		else if (tx_accept)
		begin
			tx_crc <= crc_step(tx_first ? preset_of(
				tx_setup.tx_initial_value_select,
				tx_setup.tx_checksum_width_select, user_preset) : tx_crc,
				tx_in_beat.data, tx_setup.tx_checksum_width_select);
			tx_first <= tx_in_beat.last;
		end
	end

	rfc_pkg::rfc_width_t rx_w;
	logic [15:0] rx_crc;
	logic [15:0] rx_base;
	logic [15:0] rx_prev;
	logic [7:0]  rx_b1;
	logic [7:0]  rx_b2;
	logic [1:0]  rx_count;
	logic        rx_first;
	logic [1:0]  rx_nbytes;
	logic [15:0] rx_computed;
	logic [15:0] rx_expected;
	logic [15:0] rx_received;
	logic        rx_mismatch;

	assign rx_w      = rx_setup.rx_checksum_width_select;
	assign rx_nbytes = byte_count(rx_w);
	assign rx_base   = rx_first ? preset_of(rx_setup.rx_initial_value_select,
		rx_w, user_preset) : rx_crc;
	// Checksum of the data alone: state before the checksum bytes arrived
	assign rx_computed = (rx_nbytes == 2'd2) ? rx_prev : rx_base;
	assign rx_expected = rx_setup.rx_checksum_complement
		? (rx_computed ^ width_mask(rx_w)) : rx_computed;
	assign rx_received = ((rx_nbytes == 2'd2)
		? {rx_in_beat.data, rx_b1} : {8'h00, rx_in_beat.data}) & width_mask(rx_w);
	// A frame shorter than its checksum counts as a mismatch
	assign rx_mismatch = (rx_received != rx_expected)
		|| ((rx_first ? 2'd0 : rx_count) < rx_nbytes - 2'd1);
	assign rx_end_ev = rx_in_valid && rx_in_beat.last;
	assign rx_err_ev = rx_end_ev && rx_setup.rx_checksum_verify_enable
		&& rx_nbytes != 2'd0 && rx_mismatch;

	// Receive checksum and snapshot one byte back for 16-bit frames
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_crc    <= 16'h0000;
			rx_prev   <= 16'h0000;
			rx_first  <= 1'b1;
			rx_result <= 16'h0000;
		end
		else if (rx_in_valid)
		begin
			rx_crc   <= crc_step(rx_base, rx_in_beat.data, rx_w);
			rx_prev  <= rx_base;
			rx_first <= rx_in_beat.last;
			// Computed even with verify off; software can read it
			if (rx_in_beat.last)
				rx_result <= rx_computed;
		end
	end

	// Error pin mirrors the sticky flag
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rx_checksum_error <= 1'b0;
		else
			rx_checksum_error <= status[rfc_pkg::ST_RX_ERR] || rx_err_ev;
	end

	// FIFO path: bytes are held back by the checksum length unless stored
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fifo_wr_en   <= 1'b0;
			fifo_wr_data <= 8'h00;
			rx_b1        <= 8'h00;
			rx_b2        <= 8'h00;
			rx_count     <= 2'd0;
		end
		else
		begin
			fifo_wr_en <= 1'b0;
			if (rx_in_valid)
			begin
				rx_b1    <= rx_in_beat.data;
				rx_b2    <= rx_b1;
				rx_count <= rx_in_beat.last ? 2'd0
					: (rx_count == 2'd2) ? 2'd2 : rx_count + 2'd1;
				if (rx_setup.rx_checksum_store_to_fifo || rx_nbytes == 2'd0)
				begin
					fifo_wr_en   <= 1'b1;
					fifo_wr_data <= rx_in_beat.data;
				end
				else if (rx_count >= rx_nbytes)
				begin
					fifo_wr_en   <= 1'b1;
					fifo_wr_data <= (rx_nbytes == 2'd2) ? rx_b2 : rx_b1;
				end
			end
		end
	end

endmodule : rfc_frame_crc

// ---- test/rfc_frame_crc_monitor.sv ----
`timescale 1ns/1ps
module rfc_frame_crc_monitor (
	input wire logic               sys_clk,
	input wire logic               sys_rst,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic               avs_waitrequest,
	input wire logic               irq,
	input wire logic               tx_in_valid,
	input wire rfc_pkg::rfc_beat_t tx_in_beat,
	input wire logic               tx_in_ready,
	input wire logic               tx_out_valid,
	input wire rfc_pkg::rfc_beat_t tx_out_beat,
	input wire logic               tx_out_ready,
	input wire logic               rx_in_valid,
	input wire rfc_pkg::rfc_beat_t rx_in_beat,
	input wire logic               fifo_wr_en,
	input wire logic               rx_checksum_error
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Bus answers one cycle after the request, for one cycle only
	AST_BUS_ANSWER:
	assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	AST_BUS_PULSE:
	assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer too long");
	// Output byte is held until the coder takes it
	AST_TX_HOLD:
	assert property (tx_out_valid && !tx_out_ready
		|=> tx_out_valid && $stable(tx_out_beat))
		else $error("tx byte not held");
	AST_TX_PASS:
	assert property (tx_in_valid && tx_in_ready
		|=> tx_out_valid && tx_out_beat.data == $past(tx_in_beat.data))
		else $error("tx byte not passed");
	AST_TX_GAP:
	assert property (tx_in_valid && tx_in_ready |=> !tx_in_ready)
		else $error("tx bytes too close");
	// A FIFO write always follows a received byte
	AST_FIFO_CAUSE:
	assert property (fifo_wr_en |-> $past(rx_in_valid))
		else $error("fifo write without byte");
	// Error flag rises only after a final byte, falls only on a write
	AST_ERR_RISE:
	assert property ($rose(rx_checksum_error)
		|-> $past(rx_in_valid && rx_in_beat.last))
		else $error("error flag rose early");
	AST_ERR_HOLD:
	assert property ($fell(rx_checksum_error)
		|-> $past(avs_write) || $past(avs_write, 2))
		else $error("error flag lost");

	// Main scenarios reached
	cover property ($rose(rx_checksum_error));
	cover property (tx_out_valid && tx_out_beat.last && tx_out_ready);
	cover property ($rose(irq));
	cover property (tx_out_valid && !tx_out_ready);
endmodule : rfc_frame_crc_monitor

bind rfc_frame_crc rfc_frame_crc_monitor u_rfc_frame_crc_monitor (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.irq(irq), .tx_in_valid(tx_in_valid), .tx_in_beat(tx_in_beat),
	.tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid),
	.tx_out_beat(tx_out_beat), .tx_out_ready(tx_out_ready),
	.rx_in_valid(rx_in_valid), .rx_in_beat(rx_in_beat),
	.fifo_wr_en(fifo_wr_en), .rx_checksum_error(rx_checksum_error)
);

// ---- test/rfc_coder_model.sv ----
`timescale 1ns/1ps
module rfc_coder_model (
	input  wire logic               sys_clk,
	input  wire logic               sys_rst,
	input  wire logic               slow,
	input  wire logic               tx_out_valid,
	input  wire rfc_pkg::rfc_beat_t tx_out_beat,
	output logic                    tx_out_ready,
	output logic                    rx_in_valid,
	output rfc_pkg::rfc_beat_t      rx_in_beat
);
	rfc_pkg::rfc_beat_t tx_got[$];

	// Slow mode takes a byte every other cycle so holding is exercised
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			tx_out_ready <= 1'h0;
		else
			tx_out_ready <= slow ? ~tx_out_ready : 1'h1;

	// Bytes taken by the transmit coder
	always @(posedge sys_clk)
		if (tx_out_valid === 1'h1 && tx_out_ready === 1'h1)
			tx_got.push_back(tx_out_beat);

	initial
	begin
		rx_in_valid = 1'h0;
		rx_in_beat = 9'h000;
	end

	// Receive coder sends a frame back to back, last on the final byte
	task automatic rx_send(input logic [7:0] q[$]);
		@(posedge sys_clk);
		foreach (q[i])
		begin
			rx_in_valid <= 1'h1;
			rx_in_beat <= {i == q.size() - 1, q[i]};
			@(posedge sys_clk);
		end
		rx_in_valid <= 1'h0;
		// Idle data line must not show the stale byte
		rx_in_beat <= {1'h0, ~q[q.size() - 1]};
	endtask : rx_send
endmodule : rfc_coder_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] USR = 16'h1234;
	logic               sys_clk, sys_rst, avs_read, avs_write, irq;
	logic               avs_waitrequest, tx_in_valid, tx_in_ready, slow;
	logic               tx_out_valid, tx_out_ready, rx_in_valid;
	logic               fifo_wr_en, rx_checksum_error;
	logic [9:0]         avs_address;
	logic [3:0]         avs_byteenable;
	logic [31:0]        avs_writedata, avs_readdata;
	logic [7:0]         fifo_wr_data;
	logic [7:0]         fq[$];
	rfc_pkg::rfc_beat_t tx_in_beat, tx_out_beat, rx_in_beat;
	int                 bad_count = 0;
	int                 total_checks = 0;
	int                 cyc = 0;

	rfc_frame_crc u_rfc_frame_crc (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq), .tx_in_valid(tx_in_valid), .tx_in_beat(tx_in_beat),
		.tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid),
		.tx_out_beat(tx_out_beat), .tx_out_ready(tx_out_ready),
		.rx_in_valid(rx_in_valid), .rx_in_beat(rx_in_beat),
		.fifo_wr_en(fifo_wr_en), .fifo_wr_data(fifo_wr_data),
		.rx_checksum_error(rx_checksum_error)
	);
	rfc_coder_model u_rfc_coder_model (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
		.tx_out_valid(tx_out_valid), .tx_out_beat(tx_out_beat),
		.tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid),
		.rx_in_beat(rx_in_beat)
	);

	initial
	begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Ceiling well above the roughly one thousand cycles the tests need
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	// FIFO bytes, read before the edge updates them
	always @(posedge sys_clk)
		if (fifo_wr_en === 1'h1)
			fq.push_back(fifo_wr_data);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One access, held up to the rising edge that samples waitrequest low;
	// data is taken there, then two falling edges let registered outputs
	// such as the interrupt follow the write before anything is checked
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] r);
		@(posedge sys_clk);
		avs_address <= {i, 2'h0};
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		avs_byteenable <= be;
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'h0);
		r = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		repeat (2) @(negedge sys_clk);
	endtask : bus

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, i, d, 4'hf, r);
	endtask : wr

	task automatic rdc(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] r;
		bus(1'h0, i, 32'h0000_0000, 4'hf, r);
		chk(r, e);
	endtask : rdc

	task automatic tx_send(input logic [7:0] d, input logic l);
		@(posedge sys_clk);
		tx_in_valid <= 1'h1;
		tx_in_beat <= {l, d};
		do
			@(negedge sys_clk);
		while (tx_in_ready !== 1'h1);
		@(posedge sys_clk);
		tx_in_valid <= 1'h0;
	endtask : tx_send

	// Waits for n coder bytes, then sees that no more follow
	task automatic drain(input int n);
		while (u_rfc_coder_model.tx_got.size() < n)
			@(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		chk(u_rfc_coder_model.tx_got.size(), n);
	endtask : drain

	function automatic logic [15:0] msk(input logic [1:0] w);
		return w == 2'h2 ? 16'hffff : w == 2'h1 ? 16'h00ff : 16'h001f;
	endfunction : msk

	// Start value per code and width; undefined codes give zero
	function automatic logic [15:0] pre(input logic [2:0] p,
		input logic [1:0] w);
		logic [15:0] v;
		case (p)
			3'h1: v = w == 2'h2 ? rfc_pkg::P16_A : {8'h00, rfc_pkg::P8_A};
			3'h2: v = w == 2'h2 ? rfc_pkg::P16_B : {8'h00, rfc_pkg::P8_B};
			3'h3: v = w == 2'h2 ? rfc_pkg::P16_C : {8'h00, rfc_pkg::P8_C};
			3'h6: v = USR;
			3'h7: v = 16'hffff;
			default: v = 16'h0000;
		endcase
		if (w == 2'h0 && (p == 3'h2 || p == 3'h3))
			v = 16'h0000;
		return v & msk(w);
	endfunction : pre

	// One byte into the checksum, lowest bit first
	function automatic logic [15:0] step(input logic [15:0] c,
		input logic [1:0] w, input logic [7:0] d);
		logic [15:0] p;
		p = w == 2'h2 ? rfc_pkg::POLY16 :
			w == 2'h1 ? rfc_pkg::POLY8 : rfc_pkg::POLY5;
		for (int k = 0; k < 8; k++)
			c = c[0] ^ d[k] ? (c >> 1) ^ p : c >> 1;
		return c;
	endfunction : step

	initial
	begin
		logic [31:0] r;
		logic [15:0] c, t;
		logic [7:0]  q[$];
		logic        inv, st, bad, en;
		int          n;
		sys_rst = 1'h1;
		{avs_read, avs_write, tx_in_valid, slow} = 4'h0;
		avs_address = 10'h000;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0000_0000;
		tx_in_beat = 9'h000;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'h0;
		// Reset values, reserved bit, refused and unmapped writes
		rdc(rfc_pkg::TX_SETUP_IDX, 32'h0000_0000);
		rdc(rfc_pkg::RX_SETUP_IDX, 32'h0000_0000);
		wr(rfc_pkg::TX_SETUP_IDX, 32'h0000_00ff);
		bus(1'h1, rfc_pkg::TX_SETUP_IDX, 32'h0000_0000, 4'he, r);
		rdc(rfc_pkg::TX_SETUP_IDX, 32'h0000_007f);
		wr(rfc_pkg::RX_SETUP_IDX, 32'h0000_00ff);
		rdc(rfc_pkg::RX_SETUP_IDX, 32'h0000_00ff);
		wr(8'h10, 32'h0000_00ff);
		rdc(8'h10, 32'h0000_0000);
		wr(rfc_pkg::USER_PRESET_IDX, {16'h0000, USR});
		$display("test registers done");
		// Checksum off: bytes pass and the last flag stays on the data
		wr(rfc_pkg::TX_SETUP_IDX, 32'h0000_0000);
		tx_send(8'h5a, 1'h0);
		tx_send(8'hc3, 1'h1);
		drain(2);
		chk(u_rfc_coder_model.tx_got[1], 9'h1c3);
		// Reserved width with enable set: nothing may be appended
		u_rfc_coder_model.tx_got.delete();
		wr(rfc_pkg::TX_SETUP_IDX, 32'h0000_000d);
		tx_send(8'h5a, 1'h0);
		tx_send(8'hc3, 1'h1);
		drain(2);
		chk(u_rfc_coder_model.tx_got[1], 9'h1c3);
		for (int w = 0; w < 3; w++)
			for (int p = 0; p < 8; p++)
			begin
				slow <= w[0];
				inv = p[0];
				wr(rfc_pkg::STATUS_IDX, 32'h0000_0007);
				wr(rfc_pkg::TX_SETUP_IDX, {25'h0, p[2:0], w[1:0], inv, 1'h1});
				u_rfc_coder_model.tx_got.delete();
				c = step(step(pre(p[2:0], w[1:0]), w[1:0], 8'h5a), w[1:0], 8'hc3);
				if (inv)
					c = c ^ msk(w[1:0]);
				tx_send(8'h5a, 1'h0);
				tx_send(8'hc3, 1'h1);
				n = w == 2 ? 4 : 3;
				drain(n);
				chk(u_rfc_coder_model.tx_got[1], 9'h0c3);
				chk(u_rfc_coder_model.tx_got[2], {n == 3, c[7:0]});
				if (w == 2)
					chk(u_rfc_coder_model.tx_got[3], {1'h1, c[15:8]});
				rdc(rfc_pkg::STATUS_IDX, 32'h0000_0001);
			end
		$display("test transmit done");
		for (int w = 0; w < 3; w++)
			for (int k = 0; k < 4; k++)
			begin
				st = k[0] || w == 0;
				inv = k == 1;
				bad = k > 1;
				en = k != 3;
				wr(rfc_pkg::RX_SETUP_IDX,
					{24'h0, st, k[0] ? 3'h7 : 3'h3, w[1:0], inv, en});
				wr(rfc_pkg::STATUS_IDX, 32'h0000_0007);
				c = pre(k[0] ? 3'h7 : 3'h3, w[1:0]);
				c = step(step(c, w[1:0], 8'h5a), w[1:0], 8'h3c);
				t = c ^ (inv ? msk(w[1:0]) : 16'h0000) ^ {15'h0, bad};
				q = {8'h5a, 8'h3c, t[7:0]};
				if (w == 2)
					q.push_back(t[15:8]);
				fq.delete();
				u_rfc_coder_model.rx_send(q);
				repeat (3) @(negedge sys_clk);
				chk(fq.size(), st ? q.size() : 2);
				chk({fq[0], fq[1]}, 16'h5a3c);
				chk(rx_checksum_error, bad && en);
				rdc(rfc_pkg::RESULT_IDX, {16'h0, c});
				rdc(rfc_pkg::STATUS_IDX, {29'h0, bad && en, 2'h2});
				if (bad && en)
				begin
					chk(irq, 1'h0);
					wr(rfc_pkg::MASK_IDX, 32'h0000_0004);
					chk(irq, 1'h1);
					wr(rfc_pkg::STATUS_IDX, 32'h0000_0007);
					chk({irq, rx_checksum_error}, 2'h0);
					wr(rfc_pkg::MASK_IDX, 32'h0000_0000);
				end
			end
		$display("test receive done");
		tally_and_finish();
	end
endmodule : tb_top
